// ===== core/c16_core_datapath.sv
/*
 Core datapath of a 16-bit processor, reached as an AHB-Lite slave.
 Software writes operands and a command word; the core runs it over
 instruction cycles of two clocks and reports flags and traps.
 Assumes one 100 MHz clock, a single AHB-Lite master and the c16_pkg package.
*/
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module c16_core_datapath
  import c16_pkg::*;
(
  input wire logic sys_clk_i, // System clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic clk_en_i, // Freezes all state while low; nrst_i still resets it
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [15:0] pc_o, // Program counter
  output logic busy_o, // Command in progress
  output logic trap_o // Sticky stack trap
);
  // Whole module state
  typedef struct packed {
    logic [15:0][15:0] default_work_reg; // Working registers
    logic [15:0] status; // ALU flags, loop flag, priority
    logic [1:0] core_ctrl; // Priority high bit, window enable
    logic [15:0] stack_limit; // Overflow threshold
    logic [31:0] cmd; // Command latched for execution
    logic [15:0] opa; // Operand A, memory data in
    logic [15:0] opb; // Operand B, shift count or literal
    logic [31:0] result; // Last result, address or dword
    logic [1:0] trap; // Overflow, underflow
    c16_phase_t phase; // Pipeline phase
    logic [4:0] div_cnt; // Divide cycles left
    logic div_half; // Second clock of a divide instruction cycle
    logic [31:0] div_rem; // Partial remainder and quotient
    logic [15:0] pc; // Program counter
    logic busy; // Command pending
    logic dph_wr; // Data phase is a write
    logic dph_rd; // Data phase is a read
    logic [7:0] dph_addr; // Address held for data phase
    logic [31:0] rdata; // Read data out
  } c16_state_t;
  c16_state_t st_reg;
  c16_state_t st_next;

  // Sign or zero extend a 16-bit operand to 17 bits
  function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
    ext17 = {sgn & v[15], v};
  endfunction

  // Pointer step by operand size
  function automatic logic [15:0] ptr_step(input c16_size_t sz);
    ptr_step = (sz == C16_SZ_BYTE) ? C16_STEP_BYTE : C16_STEP_WORD;
  endfunction

  // One restoring divide step over a 32-bit remainder/quotient pair
  function automatic logic [31:0] div_step(input logic [31:0] rq, input logic [15:0] d);
    logic [16:0] trial;
    logic [31:0] sh;
    sh = {rq[30:0], 1'b0};
    trial = {1'b0, sh[31:16]} - {1'b0, d};
    div_step = trial[16] ? sh : {trial[15:0], sh[15:1], 1'b1};
  endfunction

  // Decoded command fields
  c16_op_t op;
  logic [3:0] dst;
  logic [3:0] src;
  c16_size_t sz;
  logic [3:0] mode;
  logic [15:0] a_val;
  logic [15:0] b_val;
  logic [33:0] prod;
  logic [16:0] sum;
  logic [31:0] shv;
  logic [3:0] shamt;
  logic [15:0] sp_new;
  logic [15:0] rv;
  always_comb begin
    op = c16_op_t'(st_reg.cmd[C16_CMD_OP_HI:C16_CMD_OP_LO]);
    dst = st_reg.cmd[C16_CMD_DST_HI:C16_CMD_DST_LO];
    src = st_reg.cmd[C16_CMD_SRC_HI:C16_CMD_SRC_LO];
    sz = c16_size_t'(st_reg.cmd[C16_CMD_SZ_HI:C16_CMD_SZ_LO]);
    mode = st_reg.cmd[C16_CMD_MODE_HI:C16_CMD_MODE_LO];
    a_val = st_reg.default_work_reg[src];
    b_val = st_reg.opb;
    // Mode bits 0,1 choose operand signs for multiply
    prod = 34'($signed(ext17(a_val, mode[0])) * $signed(ext17(b_val, mode[1])));
    sum = (op == C16_OP_SUB) ? ({1'b0, a_val} - {1'b0, b_val}) : ({1'b0, a_val} + {1'b0, b_val});
    // Byte shifts limited to seven positions, words to fifteen
    shamt = (sz == C16_SZ_BYTE && b_val[3:0] > C16_SHIFT_BYTE_MAX) ? C16_SHIFT_BYTE_MAX : b_val[3:0];
    rv = a_val;
    if (sz == C16_SZ_BYTE) begin
      rv = {8'h00, a_val[7:0]};
    end
    // Mode bits: 0 right, 1 rotate, 2 carry from end bit
    if (mode[1]) begin
      shv = mode[0] ? ({rv, rv} >> shamt) : ({rv, rv} << shamt);
    end else begin
      shv = mode[0] ? ({rv, 16'h0000} >> shamt) : ({16'h0000, rv} << shamt);
    end
    sp_new = (op == C16_OP_PUSH) ? st_reg.default_work_reg[C16_DEFAULT_WORK_REG_SP] + C16_STEP_WORD
                                 : st_reg.default_work_reg[C16_DEFAULT_WORK_REG_SP] - C16_STEP_WORD;
  end

  // Next-state logic
  always_comb begin
    logic [7:0] a;
    logic [15:0] res;
    logic [15:0] tmp;
    logic stk_bad;
    a = 8'h00;
    res = 16'h0000;
    tmp = 16'h0000;
    stk_bad = 1'b0;
    st_next = st_reg;
    // Bus data phase: writes land now, reads already captured
    st_next.dph_wr = 1'b0;
    st_next.dph_rd = 1'b0;
    if (st_reg.dph_wr) begin
      a = st_reg.dph_addr;
      if (a == C16_OFF_CMD) begin
        st_next.cmd = hwdata_i;
        st_next.busy = 1'b1;
        st_next.phase = C16_PH_Q1;
      end else if (a == C16_OFF_OPA) begin
        st_next.opa = hwdata_i[15:0];
      end else if (a == C16_OFF_OPB) begin
        st_next.opb = hwdata_i[15:0];
      end else if (a == C16_OFF_STATUS) begin
        st_next.status = hwdata_i[15:0];
      end else if (a == C16_OFF_CORE_CTRL) begin
        st_next.core_ctrl = hwdata_i[1:0];
      end else if (a == C16_OFF_STACK_LIMIT) begin
        st_next.stack_limit = hwdata_i[15:0];
      end else if (a == C16_OFF_TRAP) begin
        st_next.trap = st_reg.trap & ~hwdata_i[1:0]; // Write one to clear
      end else if (a >= C16_OFF_DEFAULT_WORK_REG_BASE && a <= C16_OFF_DEFAULT_WORK_REG_END) begin
        st_next.default_work_reg[a[5:2]] = hwdata_i[15:0];
      end
    end
    // Address phase capture
    if (hsel_i && hready_i && htrans_i[1]) begin
      st_next.dph_wr = hwrite_i;
      st_next.dph_rd = ~hwrite_i;
      st_next.dph_addr = haddr_i[7:0];
      a = haddr_i[7:0];
      if (a == C16_OFF_CMD) begin
        st_next.rdata = st_reg.cmd;
      end else if (a == C16_OFF_OPA) begin
        st_next.rdata = {16'h0000, st_reg.opa};
      end else if (a == C16_OFF_OPB) begin
        st_next.rdata = {16'h0000, st_reg.opb};
      end else if (a == C16_OFF_STATUS) begin
        st_next.rdata = {16'h0000, st_reg.status};
      end else if (a == C16_OFF_CORE_CTRL) begin
        st_next.rdata = {30'h0, st_reg.core_ctrl};
      end else if (a == C16_OFF_STACK_LIMIT) begin
        st_next.rdata = {16'h0000, st_reg.stack_limit};
      end else if (a == C16_OFF_RESULT) begin
        st_next.rdata = st_reg.result;
      end else if (a == C16_OFF_TRAP) begin
        st_next.rdata = {29'h0, st_reg.busy, st_reg.trap};
      end else if (a >= C16_OFF_DEFAULT_WORK_REG_BASE && a <= C16_OFF_DEFAULT_WORK_REG_END) begin
        st_next.rdata = {16'h0000, st_reg.default_work_reg[a[5:2]]};
      end else begin
        st_next.rdata = 32'h0000_0000; // Unmapped reads zero
      end
    end
    // Instruction sequencing: Q1 advances PC, Q2 executes
    case (st_reg.phase)
      C16_PH_Q1: begin
        st_next.pc = st_reg.pc + C16_PC_STEP;
        st_next.phase = C16_PH_Q2;
      end
      C16_PH_Q2: begin
        st_next.phase = C16_PH_IDLE;
        st_next.busy = 1'b0;
        case (op)
          C16_OP_MOV: begin
            st_next.default_work_reg[dst] = b_val;
          end
          C16_OP_ADD, C16_OP_SUB: begin
            res = sum[15:0];
            if (sz == C16_SZ_BYTE) begin
              res = {8'h00, res[7:0]};
            end
            st_next.default_work_reg[dst] = res;
            st_next.result = {16'h0000, res};
            st_next.status[C16_ST_C] = sum[16] ^ (op == C16_OP_SUB);
            st_next.status[C16_ST_DC] = a_val[4] ^ b_val[4] ^ sum[4];
            st_next.status[C16_ST_Z] = (res == 16'h0000);
            st_next.status[C16_ST_N] = res[15];
            st_next.status[C16_ST_OV] = (a_val[15] ^ res[15]) & ~(a_val[15] ^ b_val[15] ^ (op == C16_OP_SUB));
          end
          C16_OP_ANDW: begin
            // Restricted form: always default working register
            st_next.default_work_reg[C16_DEFAULT_WORK_REG_DEFAULT] = st_reg.default_work_reg[C16_DEFAULT_WORK_REG_DEFAULT] & b_val;
          end
          C16_OP_MUL: begin
            st_next.default_work_reg[C16_DEFAULT_WORK_REG_MUL_LO] = prod[15:0];
            st_next.default_work_reg[C16_DEFAULT_WORK_REG_MUL_HI] = prod[31:16];
            st_next.result = prod[31:0];
          end
          C16_OP_DIV: begin
            // 32/16 uses reg one:zero dividend, 16/16 only reg zero
            st_next.div_rem = (sz == C16_SZ_DWORD) ? {st_reg.default_work_reg[C16_DEFAULT_WORK_REG_DIV_HI], st_reg.default_work_reg[C16_DEFAULT_WORK_REG_DIV_LO]}
                                                   : {16'h0000, st_reg.default_work_reg[C16_DEFAULT_WORK_REG_DIV_LO]};
            st_next.div_cnt = C16_DIV_ITER;
            st_next.div_half = 1'b0;
            st_next.status[C16_ST_RA] = 1'b1;
            st_next.phase = C16_PH_DIV;
            st_next.busy = 1'b1;
          end
          C16_OP_SHIFT: begin
            // Rotates take the opposite half from plain shifts
            res = (mode[0] ^ mode[1]) ? shv[31:16] : shv[15:0];
            if (sz == C16_SZ_BYTE) begin
              res = {8'h00, mode[1] ? (res[7:0] | res[15:8]) : res[7:0]};
            end
            if (mode[2]) begin
              st_next.status[C16_ST_C] = mode[0] ? a_val[0] : a_val[15];
            end
            st_next.default_work_reg[dst] = res;
            st_next.status[C16_ST_Z] = (res == 16'h0000);
          end
          C16_OP_LDIND, C16_OP_STIND: begin
            // Mode: 0 none, 1 post-inc, 2 post-dec, 3 pre-inc, 4 pre-dec
            tmp = st_reg.default_work_reg[src];
            if (mode == 4'h3) begin
              tmp = tmp + ptr_step(sz);
            end else if (mode == 4'h4) begin
              tmp = tmp - ptr_step(sz);
            end
            st_next.result = {16'h0000, tmp};
            if (mode == 4'h1) begin
              st_next.default_work_reg[src] = tmp + ptr_step(sz);
            end else if (mode == 4'h2) begin
              st_next.default_work_reg[src] = tmp - ptr_step(sz);
            end else begin
              st_next.default_work_reg[src] = tmp;
            end
            if (op == C16_OP_LDIND) begin
              st_next.default_work_reg[dst] = st_reg.opa;
            end
          end
          C16_OP_LDNEAR: begin
            // Literal address wraps inside near region
            st_next.result = {16'h0000, b_val & (C16_NEAR_LIMIT - 16'h0001)};
            st_next.default_work_reg[dst] = st_reg.opa;
          end
          C16_OP_PUSH, C16_OP_POP: begin
            if (op == C16_OP_POP && sp_new < C16_STACK_BASE) begin
              stk_bad = 1'b1;
              st_next.trap[0] = 1'b1;
            end else if (op == C16_OP_PUSH && sp_new > st_reg.stack_limit) begin
              stk_bad = 1'b1;
              st_next.trap[1] = 1'b1;
            end
            if (stk_bad) begin
              st_next.pc = C16_TRAP_VEC;
            end else begin
              st_next.default_work_reg[C16_DEFAULT_WORK_REG_SP] = sp_new;
              st_next.result = {16'h0000, (op == C16_OP_PUSH) ? st_reg.default_work_reg[C16_DEFAULT_WORK_REG_SP] : sp_new};
              if (op == C16_OP_POP) begin
                st_next.default_work_reg[dst] = st_reg.opa;
              end
            end
          end
          default: begin
          end
        endcase
      end
      C16_PH_DIV: begin
        // Two clocks per iteration; staying here keeps the PC still
        if (!st_reg.div_half) begin
          st_next.div_half = 1'b1;
        end else begin
          st_next.div_half = 1'b0;
          // Sixteen steps then quotient/remainder write-back
          if (st_reg.div_cnt > C16_DIV_ITER - C16_DIV_STEPS) begin
            st_next.div_rem = div_step(st_reg.div_rem, st_reg.opb);
          end
          st_next.div_cnt = st_reg.div_cnt - 5'h01;
          if (st_reg.div_cnt == 5'h00) begin
            st_next.default_work_reg[C16_DEFAULT_WORK_REG_DIV_LO] = st_reg.div_rem[15:0];
            st_next.default_work_reg[C16_DEFAULT_WORK_REG_DIV_HI] = st_reg.div_rem[31:16];
            st_next.result = st_reg.div_rem;
            st_next.status[C16_ST_RA] = 1'b0;
            st_next.phase = C16_PH_IDLE;
            st_next.busy = 1'b0;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // State register; frame-pointer role kept as plain register fourteen
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.stack_limit <= C16_STACK_LIMIT_RST;
      st_reg.default_work_reg[C16_DEFAULT_WORK_REG_SP] <= C16_STACK_BASE;
      st_reg.default_work_reg[C16_DEFAULT_WORK_REG_FP] <= C16_STACK_BASE;
      st_reg.pc <= C16_PC_RST;
      st_reg.phase <= C16_PH_IDLE;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  // Outputs read from the state register; bus always ready and okay
  assign pc_o = st_reg.pc;
  assign busy_o = st_reg.busy;
  assign trap_o = |st_reg.trap;
  assign hrdata_o = st_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
endmodule
`default_nettype wire

// ===== core/c16_pkg.sv
/*
 Package for the 16-bit core datapath: register offsets, field layout,
 reset values, operation codes and timing constants.
 Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package c16_pkg;
  // Register map, byte addresses
  localparam logic [7:0] C16_OFF_CMD = 8'h00;
  localparam logic [7:0] C16_OFF_OPA = 8'h04;
  localparam logic [7:0] C16_OFF_OPB = 8'h08;
  localparam logic [7:0] C16_OFF_STATUS = 8'h0c;
  localparam logic [7:0] C16_OFF_CORE_CTRL = 8'h10;
  localparam logic [7:0] C16_OFF_STACK_LIMIT = 8'h14;
  localparam logic [7:0] C16_OFF_RESULT = 8'h18;
  localparam logic [7:0] C16_OFF_TRAP = 8'h1c;
  localparam logic [7:0] C16_OFF_DEFAULT_WORK_REG_BASE = 8'h40;
  localparam logic [7:0] C16_OFF_DEFAULT_WORK_REG_END = 8'h7c;
  // Status fields
  localparam int C16_ST_C = 0;
  localparam int C16_ST_DC = 1;
  localparam int C16_ST_Z = 2;
  localparam int C16_ST_N = 3;
  localparam int C16_ST_OV = 4;
  localparam int C16_ST_RA = 5;
  localparam int C16_ST_IPL_LO = 6;
  localparam int C16_ST_IPL_HI = 8;
  // Core control fields
  localparam int C16_CC_PRIORITY_LEVEL_HIGH_BIT = 0;
  localparam int C16_CC_PSV = 1;
  // Command fields
  localparam int C16_CMD_OP_LO = 0;
  localparam int C16_CMD_OP_HI = 3;
  localparam int C16_CMD_DST_LO = 4;
  localparam int C16_CMD_DST_HI = 7;
  localparam int C16_CMD_SRC_LO = 8;
  localparam int C16_CMD_SRC_HI = 11;
  localparam int C16_CMD_SZ_LO = 12;
  localparam int C16_CMD_SZ_HI = 13;
  localparam int C16_CMD_MODE_LO = 16;
  localparam int C16_CMD_MODE_HI = 19;
  // Reset and fixed values
  localparam logic [15:0] C16_STACK_BASE = 16'h0800;
  localparam logic [15:0] C16_STACK_LIMIT_RST = 16'hffff;
  localparam logic [15:0] C16_NEAR_LIMIT = 16'h2000;
  localparam logic [15:0] C16_PC_RST = 16'h0000;
  localparam logic [15:0] C16_PC_STEP = 16'h0002;
  localparam logic [15:0] C16_TRAP_VEC = 16'h0004;
  localparam logic [15:0] C16_STEP_BYTE = 16'h0001;
  localparam logic [15:0] C16_STEP_WORD = 16'h0002;
  localparam logic [3:0] C16_SHIFT_BYTE_MAX = 4'h7;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_DEFAULT = 4'h0;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_DIV_LO = 4'h0;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_DIV_HI = 4'h1;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_MUL_LO = 4'h2;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_MUL_HI = 4'h3;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_FP = 4'he;
  localparam logic [3:0] C16_DEFAULT_WORK_REG_SP = 4'hf;
  // Timing
  localparam int C16_CLK_HZ = 100_000_000;
  localparam int C16_TCY_CLKS = 2;
  localparam int C16_DIV_TCY = 19;
  localparam logic [4:0] C16_DIV_ITER = 5'(C16_DIV_TCY - 1);
  localparam logic [4:0] C16_DIV_STEPS = 5'h10;
  // Operation codes
  typedef enum logic [3:0] {
    C16_OP_NOP = 4'h0, C16_OP_MOV = 4'h1, C16_OP_ADD = 4'h2, C16_OP_SUB = 4'h3,
    C16_OP_MUL = 4'h4, C16_OP_DIV = 4'h5, C16_OP_SHIFT = 4'h6, C16_OP_LDIND = 4'h7,
    C16_OP_STIND = 4'h8, C16_OP_PUSH = 4'h9, C16_OP_POP = 4'ha, C16_OP_LDNEAR = 4'hb,
    C16_OP_ANDW = 4'hc
  } c16_op_t;
  // Operand sizes
  typedef enum logic [1:0] {
    C16_SZ_WORD = 2'h0, C16_SZ_BYTE = 2'h1, C16_SZ_DWORD = 2'h2
  } c16_size_t;
  // Pipeline phase, Gray coded
  typedef enum logic [1:0] {
    C16_PH_IDLE = 2'b00, C16_PH_Q1 = 2'b01, C16_PH_Q2 = 2'b11, C16_PH_DIV = 2'b10
  } c16_phase_t;
endpackage

// ===== sim/c16_dp_sva.sv
/*
 Checker for the 16-bit core datapath: bus answer, reset state, command
 timing, divide span, program counter steps and stack traps.
 Assumes it is bound to c16_core_datapath and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module c16_dp_sva
  import c16_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [15:0] pc_o,
  input wire logic busy_o,
  input wire logic trap_o
);
  logic cmd_dp_reg; // Command write in data phase
  logic trp_dp_reg; // Trap register write in data phase
  logic [7:0] busy_cnt_reg; // Length of the current busy run
  logic wr_take; // Write address phase taken

  assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i;

  // Track data phases; the write data only stands in the data phase
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cmd_dp_reg <= 1'b0;
      trp_dp_reg <= 1'b0;
      busy_cnt_reg <= 8'h00;
    end else begin
      cmd_dp_reg <= wr_take && haddr_i[7:0] == C16_OFF_CMD;
      trp_dp_reg <= wr_take && haddr_i[7:0] == C16_OFF_TRAP;
      busy_cnt_reg <= busy_o ? busy_cnt_reg + 8'h01 : 8'h00;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  AST_RESET_STATE: assert property ($rose(nrst_i) |-> pc_o == 16'h0000 && !busy_o && !trap_o)
    else $error("state after reset wrong");
  AST_CMD_DONE: assert property (cmd_dp_reg && hwdata_i[3:0] != 4'h5 |-> ##[1:4] !busy_o)
    else $error("command not done within two instruction cycles");
  AST_DIV_RUNS: assert property (cmd_dp_reg && hwdata_i[3:0] == 4'h5 |-> ##4 busy_o [*8])
    else $error("divide ended too early");
  AST_BUSY_BOUND: assert property (busy_cnt_reg <= 8'd48)
    else $error("busy held too long");
  AST_PC_STEP: assert property ($changed(pc_o) |-> pc_o == $past(pc_o) + 16'h0002 || pc_o == C16_TRAP_VEC)
    else $error("program counter jumped");
  AST_TRAP_VEC: assert property ($rose(trap_o) |-> ##[0:2] pc_o == C16_TRAP_VEC)
    else $error("trap did not redirect");
  AST_TRAP_CAUSE: assert property ($rose(trap_o) |-> $past(busy_o) || $past(busy_o, 2))
    else $error("trap without command");
  AST_TRAP_STICKY: assert property (trap_o && !trp_dp_reg && !$past(trp_dp_reg) |=> trap_o)
    else $error("trap cleared by itself");
endmodule

bind c16_core_datapath c16_dp_sva i_c16_dp_sva (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pc_o(pc_o), .busy_o(busy_o), .trap_o(trap_o)
);
`default_nettype wire

// ===== sim/c16_tb.sv
/*
 Self-checking bench for the core datapath over AHB-Lite.
 Assumes a zero-wait slave; read expectations are queued and checked
 by a monitor at the end of each read data phase.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import c16_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] v;} c16_exp_t;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, busy, trap, rd_dp = 1'b0;
  logic [15:0] pc;
  int bad_count = 0, n_checks = 0;
  c16_exp_t exp_q[$], mon_e;

  always #5 clk = ~clk;

  c16_core_datapath i_c16_core_datapath (.sys_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .pc_o(pc), .busy_o(busy), .trap_o(trap));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Monitor: oldest note against the read data of each data phase
  always @(posedge clk) begin
    if (rd_dp) begin
      mon_e = exp_q.pop_front();
      chk($sformatf("reg %h", mon_e.a), mon_e.v, hrdata);
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end

  // One single transfer; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 64);
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 64);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    exp_q.push_back('{a, v});
    bus(1'b0, a, 32'h0);
  endtask

  // Command, then poll busy; two edges first since busy starts late
  task automatic cmd(input logic [3:0] op, dst, src, input logic [1:0] sz, input logic [3:0] md, output int cyc);
    bus(1'b1, C16_OFF_CMD, {12'h0, md, 2'b00, sz, src, dst, op});
    cyc = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && cyc < 100) begin @(posedge clk); cyc++; end
  endtask

  function automatic logic [7:0] wa(input int i);
    return 8'h40 + 8'(4 * i);
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200us;
    bad_count++;
    stop_test();
  end

  initial begin
    int cyc, m;
    int modes[5] = '{1, 3, 0, 2, 4}; // Byte modes first keeps word pointers even
    logic [15:0] a, b, p, ea, st;
    longint pa, pb, pr;
    void'($urandom(32'hf583ff37));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("pc", 32'h0, {16'h0, pc});
    rd(wa(15), 32'h0800);
    rd(wa(14), 32'h0800);
    rd(C16_OFF_STACK_LIMIT, 32'hffff);
    rd(C16_OFF_STATUS, 32'h0);
    bus(1'b1, 8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    bus(1'b1, C16_OFF_STATUS, 32'h1c0);
    rd(C16_OFF_STATUS, 32'h1c0);
    bus(1'b1, C16_OFF_CORE_CTRL, 32'h3);
    rd(C16_OFF_CORE_CTRL, 32'h3);
    for (m = 4; m < 14; m++) begin
      a = 16'($urandom);
      bus(1'b1, wa(m), {16'h0, a});
      rd(wa(m), {16'h0, a});
    end
    // All four sign combinations of the multiplier
    for (m = 0; m < 4; m++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      bus(1'b1, wa(4), {16'h0, a});
      bus(1'b1, C16_OFF_OPB, {16'h0, b});
      cmd(4'h4, 4'h0, 4'h4, 2'h0, 4'(m), cyc);
      pa = m[0] ? longint'($signed(a)) : longint'(a);
      pb = m[1] ? longint'($signed(b)) : longint'(b);
      pr = pa * pb;
      rd(wa(2), {16'h0, pr[15:0]});
      rd(wa(3), {16'h0, pr[31:16]});
      chk("mul span", 32'h1, {31'h0, cyc < 4});
    end
    // 32/16 divide of 0x00010000 by 3
    bus(1'b1, wa(0), 32'h0);
    bus(1'b1, wa(1), 32'h1);
    bus(1'b1, C16_OFF_OPB, 32'h3);
    cmd(4'h5, 4'h0, 4'h0, 2'h2, 4'h0, cyc);
    chk("div span", 32'h1, {31'h0, cyc >= 30 && cyc < 100});
    rd(wa(0), 32'h5555);
    rd(wa(1), 32'h1);
    // Add with carry out, then flags in status
    bus(1'b1, wa(4), 32'hffff);
    bus(1'b1, C16_OFF_OPB, 32'h1);
    cmd(4'h2, 4'h7, 4'h4, 2'h0, 4'h0, cyc);
    rd(wa(7), 32'h0);
    rd(C16_OFF_STATUS, 32'h1c7);
    bus(1'b1, wa(4), 32'h5);
    bus(1'b1, C16_OFF_OPB, 32'h7);
    cmd(4'h3, 4'h7, 4'h4, 2'h0, 4'h0, cyc);
    rd(wa(7), 32'hfffe);
    bus(1'b1, wa(4), 32'h12f0);
    bus(1'b1, C16_OFF_OPB, 32'h20);
    cmd(4'h2, 4'h7, 4'h4, 2'h1, 4'h0, cyc);
    rd(wa(7), 32'h10);
    bus(1'b1, C16_OFF_OPB, 32'h1234);
    cmd(4'h1, 4'h7, 4'h0, 2'h0, 4'h0, cyc);
    rd(wa(7), 32'h1234);
    bus(1'b1, wa(0), 32'h0ff0);
    bus(1'b1, C16_OFF_OPB, 32'h3c3c);
    cmd(4'hc, 4'h7, 4'h4, 2'h0, 4'h0, cyc);
    rd(wa(0), 32'h0c30);
    // Word rotates left and right, byte shift clamped to seven
    bus(1'b1, wa(4), 32'h1234);
    bus(1'b1, C16_OFF_OPB, 32'h4);
    cmd(4'h6, 4'h7, 4'h4, 2'h0, 4'h2, cyc);
    rd(wa(7), 32'h2341);
    cmd(4'h6, 4'h7, 4'h4, 2'h0, 4'h3, cyc);
    rd(wa(7), 32'h4123);
    bus(1'b1, wa(4), 32'h00ff);
    bus(1'b1, C16_OFF_OPB, 32'hf);
    cmd(4'h6, 4'h7, 4'h4, 2'h1, 4'h0, cyc);
    rd(wa(7), 32'h80);
    // Near literal wraps inside the lowest region
    bus(1'b1, C16_OFF_OPA, 32'hbeef);
    bus(1'b1, C16_OFF_OPB, 32'hffff);
    cmd(4'hb, 4'h8, 4'h0, 2'h0, 4'h0, cyc);
    rd(C16_OFF_RESULT, 32'h1fff);
    rd(wa(8), 32'hbeef);
    // Every pointer mode, byte and word steps
    p = 16'h1000;
    bus(1'b1, wa(5), {16'h0, p});
    for (int j = 0; j < 5; j++) begin
      m = modes[j];
      st = m[0] ? C16_STEP_BYTE : C16_STEP_WORD;
      if (m == 3) p = p + st;
      if (m == 4) p = p - st;
      ea = p;
      if (m == 1) p = p + st;
      if (m == 2) p = p - st;
      cmd(4'h7, 4'h6, 4'h5, m[0] ? 2'h1 : 2'h0, 4'(m), cyc);
      rd(C16_OFF_RESULT, {16'h0, ea});
      rd(wa(5), {16'h0, p});
    end
    // Overflow: limit at base, push must trap and leave sp alone
    bus(1'b1, C16_OFF_STACK_LIMIT, 32'h0800);
    cmd(4'h9, 4'h0, 4'h4, 2'h0, 4'h0, cyc);
    chk("trap", 32'h1, {31'h0, trap});
    rd(C16_OFF_TRAP, 32'h2);
    rd(wa(15), 32'h0800);
    bus(1'b1, C16_OFF_TRAP, 32'h2);
    rd(C16_OFF_TRAP, 32'h0);
    // Good push and pop round trip
    a = 16'($urandom);
    bus(1'b1, C16_OFF_STACK_LIMIT, 32'hffff);
    bus(1'b1, wa(4), {16'h0, a});
    cmd(4'h9, 4'h0, 4'h4, 2'h0, 4'h0, cyc);
    rd(wa(15), 32'h0802);
    rd(C16_OFF_RESULT, 32'h0800);
    bus(1'b1, C16_OFF_OPA, {16'h0, a});
    cmd(4'ha, 4'h6, 4'h0, 2'h0, 4'h0, cyc);
    rd(wa(6), {16'h0, a});
    rd(wa(15), 32'h0800);
    // Underflow from an empty stack
    cmd(4'ha, 4'h6, 4'h0, 2'h0, 4'h0, cyc);
    rd(C16_OFF_TRAP, 32'h1);
    rd(wa(15), 32'h0800);
    bus(1'b1, C16_OFF_TRAP, 32'h1);
    repeat (3) @(posedge clk);
    chk("trap", 32'h0, {31'h0, trap});
    // Second reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(wa(15), 32'h0800);
    @(posedge clk);
    chk("queue", 32'h0, 32'(exp_q.size()));
    stop_test();
  end
endmodule
`default_nettype wire
